// ==== include/oei_pkg.sv ====
package oei_pkg;
   // Register byte offsets
   localparam logic [7:0] OEI_CTRL_OFF   = 8'h00;
   localparam logic [7:0] OEI_BURST_OFF  = 8'h04;
   localparam logic [7:0] OEI_ALT_OFF    = 8'h08;
   localparam logic [7:0] OEI_RATE_OFF   = 8'h0C;
   localparam logic [7:0] OEI_MASK_OFF   = 8'h10;
   localparam logic [7:0] OEI_LANES_OFF  = 8'h14;
   localparam logic [7:0] OEI_SKEW_OFF   = 8'h18;
   localparam logic [7:0] OEI_FREQ_OFF   = 8'h1C;
   localparam logic [7:0] OEI_JUST_OFF   = 8'h20;
   localparam logic [7:0] OEI_TRIG_OFF   = 8'h24;
   localparam logic [7:0] OEI_STAT_OFF   = 8'h28;
   // Control field positions, plus the apply bit of the justification register
   localparam int OEI_TYPE_LSB  = 0;
   localparam int OEI_CAT_LSB   = 2;
   localparam int OEI_MODE_LSB  = 5;
   localparam int OEI_ITEM_LSB  = 8;
   localparam int OEI_LVL_LSB   = 12;
   localparam int OEI_LTYPE_BIT = 15;
   localparam int OEI_SUBR_LSB  = 16;
   localparam int OEI_ORATE_LSB = 20;
   localparam int OEI_APPLY_BIT = 8;
   // Sizes
   localparam int OEI_LANES     = 20;
   localparam int OEI_SKEW_W    = 6;
   localparam int OEI_SKEW_MAX  = 64;
   localparam logic [31:0] OEI_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] OEI_LFSR_SEED = 32'h0000_0001;
   localparam logic [31:0] OEI_LFSR_TAPS = 32'h8020_0003;
   // 2.0E-3 scaled to 2^32, rounded up
   localparam logic [31:0] OEI_SKIP_THR = 32'h0083_126F;
   // Encodings
   localparam logic [1:0] OEI_TYPE_OFF = 2'h0;
   localparam logic [2:0] OEI_CAT_OH   = 3'h0;
   localparam logic [2:0] OEI_CAT_GMP  = 3'h1;
   localparam logic [2:0] OEI_CAT_GFP  = 3'h2;
   localparam logic [2:0] OEI_CAT_FEC  = 3'h3;
   localparam logic [2:0] OEI_CAT_OTL  = 3'h4;
   localparam logic [3:0] OEI_FEC_POIS = 4'h0;
   localparam logic [2:0] OEI_ORATE_TOP = 3'h7;
   localparam logic [2:0] OEI_JUST_P1 = 3'h1;
   localparam logic [2:0] OEI_JUST_P3 = 3'h3;
   localparam logic [2:0] OEI_JUST_N1 = 3'h5;
   localparam logic [2:0] OEI_JUST_N2 = 3'h6;
   typedef enum logic [2:0] {
      OEI_M_SINGLE = 3'h0,
      OEI_M_BURST  = 3'h1,
      OEI_M_ALT    = 3'h2,
      OEI_M_ALL    = 3'h3,
      OEI_M_RATE   = 3'h4
   } oei_mode_t;
   typedef enum logic [2:0] {
      OEI_S_IDLE  = 3'b001,
      OEI_S_ARMED = 3'b010,
      OEI_S_RUN   = 3'b100
   } oei_state_t;
endpackage

// ==== rtl/oei_rate_gen.sv ====
`timescale 1ns/1ps
module oei_rate_gen
   import oei_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        resetn_i,
   input  wire logic        en_i,
   input  wire logic [31:0] thr_i,
   output logic             hit_o
);
   logic [31:0] lfsr_q;

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      lfsr_next = v[0] ? ((v >> 1) ^ OEI_LFSR_TAPS) : (v >> 1);
   endfunction

   // Uniform draw compared to threshold gives a memoryless error process
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lfsr_q <= OEI_LFSR_SEED;
         hit_o  <= 1'b0;
      end else begin
         hit_o <= 1'b0;
         if (en_i) begin
            lfsr_q <= lfsr_next(lfsr_q);
            hit_o  <= (lfsr_q < thr_i);
         end
      end
   end
endmodule

// ==== rtl/oei_lane_skew.sv ====
`timescale 1ns/1ps
module oei_lane_skew
   import oei_pkg::*;
(
   input  wire logic                  mclk_i,
   input  wire logic                  resetn_i,
   input  wire logic [OEI_LANES-1:0]  lane_i,
   input  wire logic [OEI_LANES-1:0]  sel_i,
   input  wire logic [OEI_SKEW_W-1:0] skew_i,
   output logic [OEI_LANES-1:0]       lane_o
);
   logic [OEI_SKEW_MAX-1:0] sr_q [OEI_LANES];

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int l = 0; l < OEI_LANES; l++) begin
            sr_q[l] <= '0;
         end
         lane_o <= '0;
      end else begin
         for (int l = 0; l < OEI_LANES; l++) begin
            sr_q[l] <= {sr_q[l][OEI_SKEW_MAX-2:0], lane_i[l]};
            // Zero skew or unselected lane passes with base latency only
            if (sel_i[l] && (skew_i != '0)) begin
               lane_o[l] <= sr_q[l][skew_i - 1'b1];
            end else begin
               lane_o[l] <= lane_i[l];
            end
         end
      end
   end
endmodule

// ==== rtl/oei_injector.sv ====
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
// Behaviour
// - Single mode corrupts one occurrence per insert trigger.
// - Burst mode inserts burst-count occurrences per trigger.
// - Alternate mode repeats every configured frame count, trigger ignored.
// - All mode corrupts every frame while selected.
// - Rate mode inserts continuously at configured rate, no trigger.
// - Type off suppresses every error insertion.
// - Mapping category applies user mask once per trigger at chosen level.
// - Framing category applies user mask using the configured mode.
// - Poisson FEC only with pseudo-random payload; forces rate mode.
// - Skip option with Poisson rate at or above 2.0E-3 spares alignment bytes.
// - Non-Poisson FEC errors go to selected sub-row, one per trigger.
// - Lane category inserts only into selected lanes.
// - Skew delays selected lanes versus unselected by configured bits.
// - Skew of zero leaves lanes aligned.
// - Lane type for skew accepted only at top output rate.
// - Frequency offset applies to line and payload rates.
// - Justification bytes inserted on request.
// - Movement is +1,+2,+3,-1,-2; applied on apply-move.
module oei_injector
   import oei_pkg::*;
(
   input  wire logic                  mclk_i,
   input  wire logic                  resetn_i,
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [7:0]            paddr_i,
   input  wire logic [31:0]           pwdata_i,
   output logic [31:0]                prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   input  wire logic                  frame_start_i,
   input  wire logic                  word_valid_i,
   input  wire logic                  align_bytes_i,
   input  wire logic                  payload_prbs_i,
   input  wire logic                  skip_alignment_bytes_option_i,
   input  wire logic [OEI_LANES-1:0]  lane_i,
   output logic [OEI_LANES-1:0]       lane_o,
   output logic                       frame_ins_o,
   output logic                       word_ins_o,
   output logic [1:0]                 ins_type_o,
   output logic [2:0]                 ins_cat_o,
   output logic [3:0]                 ins_item_o,
   output logic [2:0]                 ins_level_o,
   output logic [3:0]                 ins_subrow_o,
   output logic [15:0]                ins_mask_o,
   output logic [OEI_LANES-1:0]       ins_lanes_o,
   output logic                       lane_type_o,
   output logic [15:0]                freq_offset_o,
   output logic                       just_pulse_o,
   output logic [2:0]                 just_move_o
);
   logic [31:0]          ctrl_q;
   logic [15:0]          burst_q;
   logic [15:0]          alt_q;
   logic [31:0]          rate_q;
   logic [15:0]          mask_q;
   logic [OEI_LANES-1:0] lanes_q;
   logic [OEI_SKEW_W-1:0] skew_q;
   logic [15:0]          freq_q;
   logic [2:0]           jmove_q;
   logic                 jreq_q;
   logic [15:0]          pend_q;
   logic [15:0]          alt_cnt_q;
   logic                 rate_on_q;
   logic                 skip_q;
   logic                 align_q;
   oei_state_t           state_q;
   logic                 wr;
   logic                 trig;
   logic                 hit;
   logic [1:0]           typ;
   logic [2:0]           cat;
   logic [3:0]           item;
   logic [2:0]           mode_raw;
   logic [2:0]           mode;
   logic                 pois;
   logic                 valid_cfg;
   logic                 fire;

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[1:0] == 2'b00) && (a <= OEI_STAT_OFF);
   endfunction

   function automatic logic move_ok(input logic [2:0] m);
      move_ok = ((m >= OEI_JUST_P1) && (m <= OEI_JUST_P3)) ||
                (m == OEI_JUST_N1) || (m == OEI_JUST_N2);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Configuration decode
   assign typ      = ctrl_q[OEI_TYPE_LSB +: 2];
   assign cat      = ctrl_q[OEI_CAT_LSB +: 3];
   assign item     = ctrl_q[OEI_ITEM_LSB +: 4];
   assign mode_raw = ctrl_q[OEI_MODE_LSB +: 3];
   assign pois     = (cat == OEI_CAT_FEC) && (item == OEI_FEC_POIS);
   // Poisson without a pseudo-random payload is not a valid selection
   assign valid_cfg = (typ != OEI_TYPE_OFF) && !(pois && !payload_prbs_i);

   always_comb begin
      mode = mode_raw;
      if (cat == OEI_CAT_GMP) begin
         mode = OEI_M_SINGLE;
      end else if (cat == OEI_CAT_FEC) begin
         mode = pois ? OEI_M_RATE : OEI_M_SINGLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states
   assign pready_o = 1'b1;
   assign wr   = psel_i && penable_i && pwrite_i && addr_ok(paddr_i);
   assign trig = wr && (paddr_i == OEI_TRIG_OFF) && pwdata_i[0];

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_q  <= OEI_CTRL_RST;
         burst_q <= '0;
         alt_q   <= '0;
         rate_q  <= '0;
         mask_q  <= '0;
         lanes_q <= '0;
         skew_q  <= '0;
         freq_q  <= '0;
         jmove_q <= '0;
      end else if (wr) begin
         case (paddr_i)
            OEI_CTRL_OFF:  ctrl_q  <= pwdata_i;
            OEI_BURST_OFF: burst_q <= pwdata_i[15:0];
            OEI_ALT_OFF:   alt_q   <= pwdata_i[15:0];
            OEI_RATE_OFF:  rate_q  <= pwdata_i;
            OEI_MASK_OFF:  mask_q  <= pwdata_i[15:0];
            OEI_LANES_OFF: lanes_q <= pwdata_i[OEI_LANES-1:0];
            OEI_SKEW_OFF:  skew_q  <= pwdata_i[OEI_SKEW_W-1:0];
            OEI_FREQ_OFF:  freq_q  <= pwdata_i[15:0];
            // Illegal moves are ignored so a pending move is never corrupted
            OEI_JUST_OFF:  if (move_ok(pwdata_i[2:0])) jmove_q <= pwdata_i[2:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prdata_o  <= '0;
         pslverr_o <= 1'b0;
      end else begin
         pslverr_o <= 1'b0;
         if (psel_i && !penable_i) begin
            pslverr_o <= !addr_ok(paddr_i);
            case (paddr_i)
               OEI_CTRL_OFF:  prdata_o <= ctrl_q;
               OEI_BURST_OFF: prdata_o <= {16'h0000, burst_q};
               OEI_ALT_OFF:   prdata_o <= {16'h0000, alt_q};
               OEI_RATE_OFF:  prdata_o <= rate_q;
               OEI_MASK_OFF:  prdata_o <= {16'h0000, mask_q};
               OEI_LANES_OFF: prdata_o <= {12'h000, lanes_q};
               OEI_SKEW_OFF:  prdata_o <= {26'h000_0000, skew_q};
               OEI_FREQ_OFF:  prdata_o <= {16'h0000, freq_q};
               OEI_JUST_OFF:  prdata_o <= {28'h000_0000, jreq_q, jmove_q};
               OEI_STAT_OFF:  prdata_o <= {27'h000_0000, lane_type_o, rate_on_q,
                                           jreq_q, (pend_q != '0), frame_ins_o};
               default:       prdata_o <= '0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trigger sequencing, advanced at frame boundaries
   assign fire = frame_start_i && valid_cfg && (state_q == OEI_S_ARMED);

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= OEI_S_IDLE;
         pend_q  <= '0;
      end else begin
         case (state_q)
            OEI_S_IDLE: begin
               if (trig && (mode == OEI_M_SINGLE)) begin
                  pend_q  <= 16'h0001;
                  state_q <= OEI_S_ARMED;
               end else if (trig && (mode == OEI_M_BURST) && (burst_q != '0)) begin
                  pend_q  <= burst_q;
                  state_q <= OEI_S_ARMED;
               end
            end
            OEI_S_ARMED: begin
               if (!valid_cfg || ((mode != OEI_M_SINGLE) && (mode != OEI_M_BURST))) begin
                  pend_q  <= '0;
                  state_q <= OEI_S_IDLE;
               end else if (fire) begin
                  pend_q  <= pend_q - 16'h0001;
                  state_q <= (pend_q == 16'h0001) ? OEI_S_IDLE : OEI_S_RUN;
               end
            end
            OEI_S_RUN: begin
               state_q <= OEI_S_ARMED;
            end
            default: begin
               state_q <= OEI_S_IDLE;
               pend_q  <= '0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-frame insertion decision and latched field selection
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         frame_ins_o  <= 1'b0;
         alt_cnt_q    <= '0;
         rate_on_q    <= 1'b0;
         skip_q       <= 1'b0;
         ins_type_o   <= OEI_TYPE_OFF;
         ins_cat_o    <= OEI_CAT_OH;
         ins_item_o   <= '0;
         ins_level_o  <= '0;
         ins_subrow_o <= '0;
         ins_mask_o   <= '0;
         ins_lanes_o  <= '0;
      end else if (frame_start_i) begin
         ins_type_o   <= typ;
         ins_cat_o    <= cat;
         ins_item_o   <= item;
         ins_level_o  <= ctrl_q[OEI_LVL_LSB +: 3];
         ins_subrow_o <= ctrl_q[OEI_SUBR_LSB +: 4];
         ins_mask_o   <= mask_q;
         ins_lanes_o  <= (cat == OEI_CAT_OTL) ? lanes_q : '0;
         rate_on_q    <= valid_cfg && (mode == OEI_M_RATE);
         skip_q       <= skip_alignment_bytes_option_i && pois &&
                         (rate_q >= OEI_SKIP_THR);
         alt_cnt_q    <= '0;
         frame_ins_o  <= 1'b0;
         if (valid_cfg) begin
            case (mode)
               OEI_M_SINGLE, OEI_M_BURST: frame_ins_o <= fire;
               OEI_M_ALL: frame_ins_o <= 1'b1;
               OEI_M_ALT: begin
                  frame_ins_o <= (alt_cnt_q == '0) && (alt_q != '0);
                  alt_cnt_q   <= (alt_cnt_q + 16'h0001 >= alt_q) ? '0 :
                                 alt_cnt_q + 16'h0001;
               end
               default: frame_ins_o <= 1'b0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Continuous rate errors
   oei_rate_gen u_rate (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .en_i     (word_valid_i && rate_on_q),
      .thr_i    (rate_q),
      .hit_o    (hit)
   );

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         align_q <= 1'b0;
      end else begin
         align_q <= align_bytes_i;
      end
   end

   // Aligned with the generator's one-cycle latency
   assign word_ins_o = hit && rate_on_q && !(skip_q && align_q);

   ////////////////////////////////////////////////////////////////////////////
   // Skew, frequency and justification
   oei_lane_skew u_skew (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .lane_i   (lane_i),
      .sel_i    (lanes_q),
      .skew_i   (skew_q),
      .lane_o   (lane_o)
   );

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lane_type_o   <= 1'b0;
         freq_offset_o <= '0;
         jreq_q        <= 1'b0;
         just_pulse_o  <= 1'b0;
         just_move_o   <= '0;
      end else begin
         // Lower rates have a single lane type, so the setting is dropped
         lane_type_o   <= ctrl_q[OEI_LTYPE_BIT] &&
                          (ctrl_q[OEI_ORATE_LSB +: 3] == OEI_ORATE_TOP);
         freq_offset_o <= freq_q;
         just_pulse_o  <= 1'b0;
         if (wr && (paddr_i == OEI_JUST_OFF) && pwdata_i[OEI_APPLY_BIT] &&
             move_ok(pwdata_i[2:0])) begin
            jreq_q <= 1'b1;
         end else if (jreq_q && frame_start_i) begin
            jreq_q       <= 1'b0;
            just_pulse_o <= 1'b1;
            just_move_o  <= jmove_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_off_quiet: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      frame_start_i && (typ == OEI_TYPE_OFF) |=> !frame_ins_o)
      else $error("insertion while type off");
   a_all_every: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      frame_start_i && valid_cfg && (mode == OEI_M_ALL) |=> frame_ins_o)
      else $error("all mode missed a frame");
   a_ins_boundary: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      $rose(frame_ins_o) |-> $past(frame_start_i))
      else $error("insertion not on frame boundary");
   a_single_once: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      trig && (state_q == OEI_S_IDLE) && (mode == OEI_M_SINGLE) |=>
      (pend_q == 16'h0001))
      else $error("single trigger not armed once");
   a_burst_load: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      trig && (state_q == OEI_S_IDLE) && (mode == OEI_M_BURST) && (burst_q != '0)
      |=> (pend_q == $past(burst_q)))
      else $error("burst count not loaded");
   a_pois_rate: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      frame_start_i && pois && payload_prbs_i && (typ != OEI_TYPE_OFF) |=> rate_on_q)
      else $error("poisson did not force rate");
   a_skip_align: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      skip_q && $past(align_bytes_i) |-> !word_ins_o)
      else $error("error placed in alignment bytes");
   a_lane_type: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (ctrl_q[OEI_ORATE_LSB +: 3] != OEI_ORATE_TOP) |=> !lane_type_o)
      else $error("lane type accepted below top rate");
   a_just_frame: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      just_pulse_o |-> $past(frame_start_i) && move_ok(just_move_o))
      else $error("justification off boundary or bad move");
   a_lane_sel: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      frame_start_i && (cat != OEI_CAT_OTL) |=> (ins_lanes_o == '0))
      else $error("lanes selected outside lane category");
   c_burst_run: cover property (@(posedge mclk_i) disable iff (!resetn_i)
      (state_q == OEI_S_RUN) ##[1:1000] (state_q == OEI_S_IDLE));
   c_alt_ins: cover property (@(posedge mclk_i) disable iff (!resetn_i)
      frame_ins_o && (mode == OEI_M_ALT));
   c_rate_hit: cover property (@(posedge mclk_i) disable iff (!resetn_i) word_ins_o);
   c_just: cover property (@(posedge mclk_i) disable iff (!resetn_i) just_pulse_o);
endmodule

// ==== tb/oei_frame_src.sv ====
`timescale 1ns/1ps
module oei_frame_src #(
   parameter int FRAME_LEN = 16
) (
   input  wire logic mclk_i,
   input  wire logic resetn_i,
   output logic      frame_start_o,
   output logic      word_valid_o,
   output logic      align_o
);
   int pos_q;
   // Back-to-back frames; the first two words carry the alignment bytes
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pos_q <= 0;
         frame_start_o <= 1'b0;
         word_valid_o <= 1'b0;
         align_o <= 1'b0;
      end else begin
         pos_q <= (pos_q == FRAME_LEN - 1) ? 0 : pos_q + 1;
         frame_start_o <= (pos_q == FRAME_LEN - 1);
         word_valid_o <= 1'b1;
         align_o <= (pos_q == FRAME_LEN - 1) || (pos_q == 0);
      end
   end
endmodule

// ==== tb/test_otn_error_insertion.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module test_otn_error_insertion
   import oei_pkg::*;
;
   typedef struct {logic w; logic [31:0] d; logic e;} oei_note_t;
   logic mclk_i = 0, resetn_i = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic pready, pslverr, fs, wv, al, prbs = 0, skip = 0, fs_q = 0, a1 = 0;
   logic fr_ins, w_ins, l_type, j_pulse;
   logic [2:0] j_move, cat, lvl;
   logic [1:0] typ_o;
   logic [3:0] subr, item_o;
   logic [15:0] freq, mask;
   logic [2:0] moves [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h4};
   logic [19:0] lane_in = 0, lane_out, lanes;
   logic [7:0][19:0] hist;
   int fail_count = 0, n_checks = 0, c, k;
   oei_note_t apb_q[$], nt;
   logic fr_q[$];
   always #2.5 mclk_i = ~mclk_i;
   oei_injector oei_injector_inst (.mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .frame_start_i(fs),
      .word_valid_i(wv), .align_bytes_i(al), .payload_prbs_i(prbs),
      .skip_alignment_bytes_option_i(skip), .lane_i(lane_in), .lane_o(lane_out),
      .frame_ins_o(fr_ins), .word_ins_o(w_ins), .ins_type_o(typ_o), .ins_cat_o(cat),
      .ins_item_o(item_o), .ins_level_o(lvl), .ins_subrow_o(subr), .ins_mask_o(mask),
      .ins_lanes_o(lanes), .lane_type_o(l_type), .freq_offset_o(freq),
      .just_pulse_o(j_pulse), .just_move_o(j_move));
   oei_frame_src oei_frame_src_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
      .frame_start_o(fs), .word_valid_o(wv), .align_o(al));
   ////////////////////////////////////////////////////////////////////////////
   // Monitor: every APB answer retires the oldest note; a frame decision retires the oldest fr_q entry, if there is one
   always @(posedge mclk_i) begin
      fs_q <= fs;
      a1 <= al;
      lane_in <= 20'($urandom);
      hist <= {hist[6:0], lane_in};
      if (psel && penable && pready) begin
         nt = apb_q.pop_front();
         if (!nt.w) `CHK(prdata, nt.d)
         `CHK(pslverr, nt.e)
      end
      if (fs_q && fr_q.size() > 0) `CHK(fr_ins, fr_q.pop_front())
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic e);
      apb_q.push_back('{w, d, e});
      @(posedge mclk_i);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1;
      do @(posedge mclk_i); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e = 0);
      acc(1, a, d, e);
   endtask
   task automatic sync();
      do @(posedge mclk_i); while (fs !== 1'b1);
   endtask
   task automatic frames(input logic [7:0] p, input int n);
      for (int i = 0; i < n; i++) begin
         sync();
         fr_q.push_back(p[i]);
      end
      repeat (2) @(posedge mclk_i);
   endtask
   task automatic wcount(input int n);
      c = 0;
      repeat (n) begin
         @(posedge mclk_i);
         if (a1 && skip) `CHK(w_ins, 1'b0)
         c += int'(w_ins === 1'b1);
      end
   endtask
   function automatic logic [31:0] cf(input int t, input int ct, input int m);
      return 32'(t | (ct << OEI_CAT_LSB) | (m << OEI_MODE_LSB));
   endfunction
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk_i);
      fail_count++;
      stop_test();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h0000_fb26));
      repeat (6) @(posedge mclk_i);
      resetn_i <= 1;
      acc(0, OEI_CTRL_OFF, 0, 0);
      acc(0, 8'h2C, 0, 1);
      wr(8'h2C, 32'h0000_00FF, 1);
      r = $urandom;
      wr(OEI_FREQ_OFF, r);
      acc(0, OEI_FREQ_OFF, {16'h0000, r[15:0]}, 0);
      `CHK(freq, r[15:0])
      wr(OEI_CTRL_OFF, cf(1, 0, 0));
      sync();
      wr(OEI_TRIG_OFF, 1);
      frames(8'h01, 3);
      wr(OEI_BURST_OFF, 3);
      wr(OEI_CTRL_OFF, cf(1, 0, 1));
      sync();
      wr(OEI_TRIG_OFF, 1);
      frames(8'h07, 4);
      wr(OEI_ALT_OFF, 3);
      wr(OEI_CTRL_OFF, cf(1, 0, 2));
      sync();
      c = 0;
      repeat (6) begin
         sync();
         @(posedge mclk_i);
         c += int'(fr_ins === 1'b1);
      end
      `CHK(c, 2)
      r = $urandom;
      wr(OEI_LANES_OFF, r);
      wr(OEI_CTRL_OFF, cf(1, 4, 3) | 32'h0005_0000);
      frames(8'h07, 3);
      `CHK(lanes, r[19:0])
      `CHK(subr, 4'h5)
      `CHK(cat, 3'h4)
      wr(OEI_CTRL_OFF, cf(0, 0, 3));
      frames(8'h00, 2);
      // Mapping category stays single shot although all frames is selected
      r = $urandom;
      wr(OEI_MASK_OFF, r);
      wr(OEI_CTRL_OFF, cf(1, 1, 3) | 32'h0000_3200);
      sync();
      wr(OEI_TRIG_OFF, 1);
      frames(8'h01, 2);
      `CHK(mask, r[15:0])
      `CHK(lvl, 3'h3)
      `CHK(item_o, 4'h2)
      `CHK(typ_o, 2'h1)
      wr(OEI_CTRL_OFF, cf(1, 2, 1));
      sync();
      wr(OEI_TRIG_OFF, 1);
      frames(8'h07, 4);
      `CHK(cat, 3'h2)
      wr(OEI_CTRL_OFF, cf(1, 3, 3) | 32'h0009_0100);
      sync();
      wr(OEI_TRIG_OFF, 1);
      frames(8'h01, 2);
      `CHK(subr, 4'h9)
      wr(OEI_RATE_OFF, 32'hFFFF_FFFF);
      wr(OEI_CTRL_OFF, cf(1, 0, 4));
      sync();
      sync();
      wcount(16);
      `CHK(c >= 14, 1'b1)
      wr(OEI_CTRL_OFF, cf(1, 3, 0));
      sync();
      sync();
      wcount(16);
      `CHK(c, 0)
      prbs <= 1;
      skip <= 1;
      sync();
      sync();
      wcount(48);
      `CHK(c >= 30, 1'b1)
      wr(OEI_LANES_OFF, 1);
      wr(OEI_SKEW_OFF, 3);
      repeat (10) @(posedge mclk_i);
      repeat (4) begin
         @(negedge mclk_i);
         `CHK(lane_out[1:0], {hist[0][1], hist[3][0]})
      end
      wr(OEI_SKEW_OFF, 0);
      repeat (10) @(posedge mclk_i);
      @(negedge mclk_i);
      `CHK(lane_out, hist[0])
      wr(OEI_CTRL_OFF, 32'h0000_8000);
      sync();
      repeat (2) @(posedge mclk_i);
      `CHK(l_type, 1'b0)
      wr(OEI_CTRL_OFF, 32'h0070_8000);
      sync();
      repeat (2) @(posedge mclk_i);
      `CHK(l_type, 1'b1)
      foreach (moves[i]) begin
         r = {23'h0, 1'b1, 5'h0, moves[i]};
         wr(OEI_JUST_OFF, r);
         k = 0;
         while (j_pulse !== 1'b1 && k < 64) begin
            @(posedge mclk_i);
            k++;
         end
         `CHK(k < 64, r[2:0] != 3'h4)
         if (k < 64) `CHK(j_move, r[2:0])
      end
      stop_test();
   end
endmodule
